//--- src/gmo_object_placement.sv
/*
 * Page translation, status page writes and batch buffer walking.
 * Assumes memory answers reads in order with one outstanding read and
 * that the driver sets bases and sizes while the block is idle.
 */
// Summary of operation
// - Translate graphics addresses through tables of 32-bit page entries, global or per-process.
// - Global table is contiguous, 128KB, 256KB or 512KB in size.
// - Per-process table may also be 64KB, chosen by i_second_table_size.
// - Device reports status by bus-master writes into the status page.
// - Ring length handling accepts lengths up to 2MB and no more.
// - Batch end address names the last valid 64-bit word.
// - Batch fetches are main memory reads, never snooped.
// - Batch fetch handles buffers up to 4GB long.
`timescale 1ns/1ns
module gmo_object_placement
  import gmo_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [31:0] i_table_base_control,
  input wire logic [1:0] i_table_size,
  input wire logic [31:0] i_second_table_base_control,
  input wire logic [1:0] i_second_table_size,
  input wire logic [31:0] i_status_page_address,
  input wire logic [31:0] i_ring_length,
  input wire gmo_mem_req_t i_xlate_req,
  input wire logic i_xlate_per_process,
  input wire gmo_mem_req_t i_status_req,
  input wire logic [31:0] i_batch_start,
  input wire logic [31:0] i_batch_end,
  input wire logic i_batch_launch_command,
  input wire gmo_mem_rsp_t i_mem_rsp,
  input wire logic i_mem_ready,
  output gmo_mem_req_t o_mem_rd,
  output logic o_mem_snoop,
  output gmo_mem_req_t o_mem_wr,
  output gmo_mem_rsp_t o_xlate_rsp,
  output logic o_xlate_fault,
  output gmo_mem_rsp_t o_batch_qw_addr,
  output logic o_batch_busy,
  output logic o_ring_len_ok
);
  typedef enum logic [1:0] {GMO_IDLE, GMO_XLATE, GMO_BATCH} gmo_state_t;

  gmo_state_t state_r, state_nxt;
  gmo_mem_req_t rd_r, rd_nxt, wr_r, wr_nxt;
  gmo_mem_rsp_t xrsp_r, xrsp_nxt, bqw_r, bqw_nxt;
  logic fault_r, fault_nxt, busy_r, busy_nxt, ring_ok_r, ring_ok_nxt;
  logic [11:0] offs_r, offs_nxt;
  logic [31:0] bcur_r, bcur_nxt;
  logic [31:0] tbase;
  logic [18:0] limit;
  // Full-width entry offset so a far page cannot wrap back into the table
  logic [21:0] ent_off;

  function automatic logic [18:0] size_limit(input logic [1:0] sz);
    if (sz == GMO_SIZE_64K) begin
      return GMO_LIMIT_64K;
    end else if (sz == GMO_SIZE_128K) begin
      return GMO_LIMIT_128K;
    end else if (sz == GMO_SIZE_256K) begin
      return GMO_LIMIT_256K;
    end
    return GMO_LIMIT_512K;
  endfunction

  always_comb begin
    // Low 12 bits ignored, so a sloppy base still lands on a page
    tbase = i_xlate_per_process ? i_second_table_base_control : i_table_base_control;
    tbase[GMO_PAGE_SHIFT-1:0] = '0;
    // Global table never reports the 64KB size; treat that code as 128KB
    limit = i_xlate_per_process ? size_limit(i_second_table_size) :
      ((i_table_size == GMO_SIZE_64K) ? GMO_LIMIT_128K : size_limit(i_table_size));
    ent_off = 22'(i_xlate_req.addr[GMO_ADDR_W-1:GMO_PAGE_SHIFT]) << GMO_PTE_BYTES_SHIFT;
  end

  always_comb begin
    state_nxt = state_r;
    rd_nxt = rd_r;
    wr_nxt = '0;
    xrsp_nxt = '0;
    bqw_nxt = '0;
    fault_nxt = 1'b0;
    busy_nxt = busy_r;
    offs_nxt = offs_r;
    bcur_nxt = bcur_r;
    ring_ok_nxt = (i_ring_length <= GMO_RING_MAX_BYTES);
    if (i_status_req.valid) begin
      wr_nxt.valid = 1'b1;
      wr_nxt.addr = {i_status_page_address[31:GMO_PAGE_SHIFT],
        i_status_req.addr[GMO_PAGE_SHIFT-1:0]};
      wr_nxt.data = i_status_req.data;
    end
    case (state_r)
      GMO_IDLE: begin
        if (i_batch_launch_command) begin
          bcur_nxt = {i_batch_start[31:GMO_QW_SHIFT], 3'h0};
          busy_nxt = 1'b1;
          state_nxt = GMO_BATCH;
        end else if (i_xlate_req.valid) begin
          // Out-of-range page is refused instead of reading past the table
          if ({10'h0, ent_off} > {13'h0, limit} - 32'h3) begin
            fault_nxt = 1'b1;
          end else begin
            rd_nxt.valid = 1'b1;
            rd_nxt.addr = tbase + {10'h0, ent_off};
            rd_nxt.data = GMO_RESET_WORD;
            offs_nxt = i_xlate_req.addr[GMO_PAGE_SHIFT-1:0];
            state_nxt = GMO_XLATE;
          end
        end
      end
      GMO_XLATE: begin
        if (rd_r.valid && i_mem_ready) begin
          rd_nxt.valid = 1'b0;
        end
        if (i_mem_rsp.valid) begin
          xrsp_nxt.valid = 1'b1;
          xrsp_nxt.data = {i_mem_rsp.data[31:GMO_PAGE_SHIFT], offs_r};
          state_nxt = GMO_IDLE;
        end
      end
      GMO_BATCH: begin
        // 32-bit counter walks up to 4GB; end is inclusive
        bqw_nxt.valid = 1'b1;
        bqw_nxt.data = bcur_r;
        if (bcur_r[31:GMO_QW_SHIFT] >= i_batch_end[31:GMO_QW_SHIFT]) begin
          busy_nxt = 1'b0;
          state_nxt = GMO_IDLE;
        end else begin
          bcur_nxt = bcur_r + 32'h8;
        end
      end
      default: begin
        state_nxt = GMO_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= GMO_IDLE;
      rd_r <= '0;
      wr_r <= '0;
      xrsp_r <= '0;
      bqw_r <= '0;
      fault_r <= 1'b0;
      busy_r <= 1'b0;
      ring_ok_r <= 1'b0;
      offs_r <= '0;
      bcur_r <= '0;
    end else begin
      state_r <= state_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      xrsp_r <= xrsp_nxt;
      bqw_r <= bqw_nxt;
      fault_r <= fault_nxt;
      busy_r <= busy_nxt;
      ring_ok_r <= ring_ok_nxt;
      offs_r <= offs_nxt;
      bcur_r <= bcur_nxt;
    end
  end

  assign o_mem_rd = rd_r;
  assign o_mem_snoop = 1'b0;
  assign o_mem_wr = wr_r;
  assign o_xlate_rsp = xrsp_r;
  assign o_xlate_fault = fault_r;
  assign o_batch_qw_addr = bqw_r;
  assign o_batch_busy = busy_r;
  assign o_ring_len_ok = ring_ok_r;

  sequence s_status_in;
    i_status_req.valid;
  endsequence

  status_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_status_in |=> o_mem_wr.valid &&
      o_mem_wr.addr[31:12] == $past(i_status_page_address[31:12]))
    else $error("status write missing");
  ring_limit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_ring_length) == 32'h0020_0001 |-> !o_ring_len_ok)
    else $error("ring length over limit accepted");
  entry_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state_r == GMO_IDLE && !i_batch_launch_command && i_xlate_req.valid && !i_xlate_per_process
    && i_xlate_req.addr[31:12] < 20'h8000 |=> o_mem_rd.valid &&
      o_mem_rd.addr == {$past(i_table_base_control[31:12]), 12'h0} +
      {$past(i_xlate_req.addr[31:12]), 2'h0})
    else $error("wrong entry address");
  xlate_data_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state_r == GMO_XLATE && i_mem_rsp.valid |=> o_xlate_rsp.valid &&
      o_xlate_rsp.data[31:12] == $past(i_mem_rsp.data[31:12]))
    else $error("translation result wrong");
  no_snoop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_batch_busy |-> !o_mem_snoop)
    else $error("batch fetch snooped");
  batch_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_batch_qw_addr.valid && o_batch_qw_addr.data[31:3] == i_batch_end[31:3] |=> !o_batch_busy)
    else $error("batch did not stop at last word");
  batch_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_batch_qw_addr.valid ##1 o_batch_qw_addr.valid |->
      o_batch_qw_addr.data == $past(o_batch_qw_addr.data) + 32'h8)
    else $error("batch step not one word");
  size_fault_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state_r == GMO_IDLE && !i_batch_launch_command && i_xlate_req.valid &&
      i_xlate_per_process && i_second_table_size == 2'h0 &&
      i_xlate_req.addr[31:12] >= 20'h4000 |=> o_xlate_fault)
    else $error("64KB table overrun not refused");
  batch_align_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_batch_qw_addr.valid |-> o_batch_qw_addr.data[2:0] == 3'h0)
    else $error("batch address not word aligned");
endmodule

//--- src/gmo_pkg.sv
/*
 * Shared constants and carriers for the memory object placement block.
 * Assumes a single 100 MHz clock and a synchronous active-high reset.
 */
package gmo_pkg;
  localparam int unsigned GMO_ADDR_W = 32;
  localparam int unsigned GMO_PAGE_SHIFT = 12;
  localparam int unsigned GMO_PTE_BYTES_SHIFT = 2;
  localparam int unsigned GMO_QW_SHIFT = 3;
  localparam logic [31:0] GMO_RING_MAX_BYTES = 32'h0020_0000;
  localparam logic [1:0] GMO_SIZE_64K = 2'h0;
  localparam logic [1:0] GMO_SIZE_128K = 2'h1;
  localparam logic [1:0] GMO_SIZE_256K = 2'h2;
  localparam logic [1:0] GMO_SIZE_512K = 2'h3;
  localparam logic [18:0] GMO_LIMIT_64K = 19'h0FFFF;
  localparam logic [18:0] GMO_LIMIT_128K = 19'h1FFFF;
  localparam logic [18:0] GMO_LIMIT_256K = 19'h3FFFF;
  localparam logic [18:0] GMO_LIMIT_512K = 19'h7FFFF;
  localparam logic [31:0] GMO_RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } gmo_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } gmo_mem_rsp_t;
endpackage

//--- tb/gmo_mem_model.sv
/*
 * Behavioural system memory for entry reads: data is ~address.
 * Assumes one outstanding read and a driver-side sample after #1.
 */
`timescale 1ns/1ns
module gmo_mem_model
  import gmo_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_slow,
  input wire gmo_mem_req_t i_rd,
  output logic o_ready,
  output gmo_mem_rsp_t o_rsp
);
  int wait_n = 0;
  logic [31:0] held = 32'h0;
  initial begin
    o_ready = 1'b0;
    o_rsp = '0;
  end
  // Plain unsnooped store holding both tables' entries
  // One memory space for all fetches
  always @(posedge i_clk) begin
    #1;
    if (o_ready) begin
      o_ready = 1'b0;
      o_rsp = '{1'b1, ~held};
    end else begin
      // Idle data toggles, never a stale match
      o_rsp = '{1'b0, ~o_rsp.data};
      if (i_rd.valid === 1'b1) begin
        held = i_rd.addr;
        if (wait_n < (i_slow ? 3 : 0)) begin
          wait_n++;
        end else begin
          wait_n = 0;
          o_ready = 1'b1;
        end
      end
    end
  end
endmodule

//--- tb/test_gpu_memory_object_placement.sv
/*
 * Self-checking bench for the placement block with a memory model.
 * Assumes the package constants and the hand-over latencies.
 */
`timescale 1ns/1ns
module test_gpu_memory_object_placement;
  import gmo_pkg::*;
  logic i_clk, i_rst, launch, pp, slow, ready, snoop, fault, busy, len_ok;
  logic [1:0] gsz, psz;
  logic [31:0] ring, bstart, bend;
  gmo_mem_req_t xreq, sreq, rd, wr;
  gmo_mem_rsp_t rsp, xrsp, qw;
  int errors = 0;
  int compares = 0;
  gmo_object_placement DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_table_base_control(32'h0010_0000), .i_table_size(gsz),
    .i_second_table_base_control(32'h0020_0000), .i_second_table_size(psz),
    .i_status_page_address(32'h0030_0000), .i_ring_length(ring), .i_xlate_req(xreq),
    .i_xlate_per_process(pp), .i_status_req(sreq), .i_batch_start(bstart),
    .i_batch_end(bend), .i_batch_launch_command(launch), .i_mem_rsp(rsp),
    .i_mem_ready(ready), .o_mem_rd(rd), .o_mem_snoop(snoop), .o_mem_wr(wr),
    .o_xlate_rsp(xrsp), .o_xlate_fault(fault), .o_batch_qw_addr(qw),
    .o_batch_busy(busy), .o_ring_len_ok(len_ok));
  gmo_mem_model mem (.i_clk(i_clk), .i_slow(slow), .i_rd(rd), .o_ready(ready), .o_rsp(rsp));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  task automatic xlate(input logic p, input logic [31:0] b, input logic [31:0] a,
                       input logic f);
    logic [31:0] e;
    e = ~(b + ((a >> 12) << 2));
    step();
    pp = p;
    xreq = '{1'b1, a, 32'h0};
    step();
    xreq.valid = 1'b0;
    for (int n = 0; n < 20 && xrsp.valid !== 1'b1 && fault !== 1'b1; n++) step();
    chk({31'h0, fault}, {31'h0, f});
    if (!f) chk(xrsp.data, {e[31:12], a[11:0]});
    chk({31'h0, snoop}, 32'h0);
    $display("xlate %h done", a);
  endtask
  task automatic status_test();
    step();
    sreq = '{1'b1, 32'h0000_0ABC, 32'h1234_5678};
    step();
    sreq.valid = 1'b0;
    chk({31'h0, wr.valid}, 32'h1);
    chk(wr.addr, 32'h0030_0ABC);
    chk(wr.data, 32'h1234_5678);
    $display("status test done");
  endtask
  task automatic batch_test();
    int k;
    k = 0;
    bstart = 32'hFFFF_FFE8;
    bend = 32'hFFFF_FFF8;
    step();
    launch = 1'b1;
    step();
    launch = 1'b0;
    chk({31'h0, busy}, 32'h1);
    for (int n = 0; n < 20 && (n == 0 || busy === 1'b1 || qw.valid === 1'b1); n++) begin
      if (qw.valid === 1'b1) begin
        chk(qw.data, bstart + 32'(k * 8));
        k++;
      end
      step();
    end
    chk(32'(k), 32'h3);
    chk({31'h0, busy}, 32'h0);
    $display("batch test done");
  endtask
  task automatic ring_test(input logic [31:0] len, input logic ok);
    ring = len;
    step();
    step();
    chk({31'h0, len_ok}, {31'h0, ok});
    $display("ring test %h done", len);
  endtask
  task automatic give_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
  initial begin
    {i_rst, launch, pp, slow} = 4'h9;
    {gsz, psz} = 4'h4;
    {ring, bstart, bend} = '0;
    xreq = '0;
    sreq = '0;
    repeat (3) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    slow = 1'b0;
    xlate(1'b0, 32'h0010_0000, 32'h0034_5678, 1'b0);
    slow = 1'b1;
    xlate(1'b0, 32'h0010_0000, 32'h07FF_F123, 1'b0);
    slow = 1'b0;
    xlate(1'b0, 32'h0010_0000, 32'h0800_0000, 1'b1);
    gsz = 2'h0;
    xlate(1'b0, 32'h0010_0000, 32'h07FF_F000, 1'b0);
    xlate(1'b0, 32'h0010_0000, 32'h0800_0000, 1'b1);
    gsz = 2'h2;
    xlate(1'b0, 32'h0010_0000, 32'h0FFF_F000, 1'b0);
    xlate(1'b0, 32'h0010_0000, 32'h1000_0000, 1'b1);
    gsz = 2'h3;
    xlate(1'b0, 32'h0010_0000, 32'h1FFF_FABC, 1'b0);
    xlate(1'b0, 32'h0010_0000, 32'h2000_0000, 1'b1);
    psz = 2'h0;
    xlate(1'b1, 32'h0020_0000, 32'h03FF_F123, 1'b0);
    xlate(1'b1, 32'h0020_0000, 32'h0400_0000, 1'b1);
    status_test();
    batch_test();
    ring_test(32'h0020_0000, 1'b1);
    ring_test(32'h0020_0001, 1'b0);
    give_verdict();
  end
endmodule
